// ### design/trap_entry_exit_unit.sv
// Trap entry and exit unit: cause, return PC, fault value, status and privilege.

// Summary of operation
// - Cause bit 31 is one for interrupts, zero for exceptions.
// - Interrupt code is its number: 2 nmi, 12 tick timer, 14 software, 16-255 external.
// - Fetch side codes: 0 misaligned, 1 access error, 2 illegal, 3 breakpoint.
// - Data side codes 4 to 7; access errors arrive imprecisely, late.
// - Environment call from user gives code 8, from machine code 11.
// - Handler base is vector bits 31:2; mode 0 uses that one address.
// - Mode 1 branches to base plus trap number times four.
// - Vector slots are fetched as ordinary code, any instruction allowed.
// - Exception entry saves the PC of the faulting instruction.
// - Interrupt entry saves the PC of the next unexecuted instruction.
// - Return PC is software writable and used by the next mret.
// - Memory access faults record the faulting address as fault value.
// - Illegal instruction records its encoding as fault value.
// - Hardware breakpoint records the matching PC as fault value.
// - Other exceptions and all interrupts clear the fault value.
// - Entry copies the interrupt enable into the previous enable bit.
// - Entry records the prior privilege in the previous privilege field.
// - Entry leaves the interrupt enable unchanged to allow nesting.
// - Any trap switches privilege to machine mode.
// - mret redirects fetch to the saved return PC.
// - mret restores enable from previous enable and privilege from field.
// - mret with field 00 enters user mode, 11 stays in machine mode.
// - After reset the core runs in machine mode.
module trap_entry_exit_unit
    import trap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input trap_req_t trap_req,
    input wire logic mret_req,
    input wire logic csr_rd,
    input csr_req_t csr_req,
    output logic [31:0] csr_rdata,
    output redirect_t redirect,
    output logic [1:0] priv_mode,
    output logic irq_enable
);

    // Interface timing, as seen by the pipeline:
    // - a trap, an mret or a CSR write is taken on the edge where it is presented;
    // - the redirect and all register updates appear one cycle later, together;
    // - the redirect stands for one cycle only, privilege and enable until changed;
    // - read data follows its strobe by one cycle and reads zero otherwise.
    // Priority is trap, then mret, then CSR write; the losers are not retried.
    // Limitations: only user and machine privilege exist, and vectored mode
    // offsets by the low 30 code bits, plenty for trap numbers up to 255.
    // Reserved vector modes 2 and 3 fall back to the single entry address.
    // The fault value is taken from the pipeline as reported; the pipeline is
    // expected to give zero for a software breakpoint and a hardware match PC.
    // Access errors arrive late, so their return PC may lie past the fault.
    // A CSR read in the same cycle as a trap sees the state before the trap.
    // Status bits other than enable, previous enable and previous privilege
    // read zero and ignore writes.
    // No counters and no long timing: every response takes one cycle.
    // All state lives in one packed struct: one process computes the next copy,
    // one register stores it, and every output is a field of that register.

    // State register and its next value
    trap_state_t s_q;
    trap_state_t s_d;

    // Memory access faults: misaligned or failed fetch, load and store
    function automatic logic is_mem_fault(input logic [30:0] code);
        logic f;
        f = 1'b0;
        unique case (code)
            EXC_INSN_MISALIGN, EXC_FETCH_ACCESS: begin
                f = 1'b1;
            end
            EXC_LOAD_MISALIGN, EXC_LOAD_ACCESS: begin
                f = 1'b1;
            end
            // Access errors are imprecise: the address is kept, the PC may be late
            EXC_STORE_MISALIGN, EXC_STORE_ACCESS: begin
                f = 1'b1;
            end
            default: begin
                f = 1'b0;
            end
        endcase
        return f;
    endfunction

    // Fault value chosen per cause; ecall, interrupts and the rest read zero
    function automatic logic [31:0] fault_value(input trap_req_t r);
        logic [31:0] v;
        v = RESET_WORD;
        if (!r.is_irq) begin
            if (is_mem_fault(r.code)) begin
                v = r.value;
            end
            if (r.code == EXC_ILLEGAL_INSN) begin
                v = r.value;
            end
            // Breakpoint value comes from the pipeline: match PC, or zero for ebreak
            if (r.code == EXC_BREAKPOINT) begin
                v = r.value;
            end
        end
        return v;
    endfunction

    // Vector slot offset: four bytes per trap number
    function automatic logic [31:0] vector_offset(input logic [30:0] code);
        logic [31:0] o;
        // Top code bit would shift out; trap numbers stop at 255 anyway
        o = {code[29:0], 2'h0};
        return o;
    endfunction

    // Handler address from base and mode; reserved modes behave as direct
    function automatic logic [31:0] handler_addr(input logic [31:0] tvec, input logic [30:0] code);
        logic [31:0] base;
        base = {tvec[31:TVEC_BASE_LSB], 2'h0};
        if (tvec[1:0] == TVEC_MODE_VECTORED) begin
            // Slot holds an instruction fetched normally, usually a jump
            return base + vector_offset(code);
        end
        return base;
    endfunction

    // Status word image with unused bits reading zero
    function automatic logic [31:0] status_word(input trap_state_t s);
        logic [31:0] w;
        w = RESET_WORD;
        w[STATUS_MIE_BIT] = s.mie;
        w[STATUS_MPIE_BIT] = s.mpie;
        w[STATUS_MPP_MSB:STATUS_MPP_LSB] = s.mpp;
        return w;
    endfunction

    // Register selects; the same decode serves the read port
    typedef struct packed {
        logic status;
        logic tvec;
        logic epc;
        logic cause;
        logic tval;
    } csr_sel_t;

    // One-hot select for a CSR address; unmapped addresses select nothing
    function automatic csr_sel_t csr_select(input logic [11:0] addr);
        csr_sel_t sel;
        sel = '0;
        unique case (addr)
            CSR_STATUS: begin
                sel.status = 1'b1;
            end
            CSR_TVEC: begin
                sel.tvec = 1'b1;
            end
            CSR_EPC: begin
                sel.epc = 1'b1;
            end
            CSR_CAUSE: begin
                sel.cause = 1'b1;
            end
            CSR_TVAL: begin
                sel.tval = 1'b1;
            end
            default: begin
                sel = '0;
            end
        endcase
        return sel;
    endfunction

    // Cause word: interrupt flag on top, number or exception code below
    // The pipeline reports codes already in the documented numbering
    function automatic logic [31:0] cause_word(input trap_req_t r);
        logic [31:0] w;
        w = RESET_WORD;
        w[CAUSE_INT_BIT] = r.is_irq;
        w[CAUSE_CODE_MSB:0] = r.code;
        return w;
    endfunction

    // Only user and machine exist; any other previous-privilege value counts as machine
    // so that a stray field value can never lower privilege
    function automatic logic [1:0] legal_priv(input logic [1:0] p);
        logic [1:0] q;
        q = PRIV_MACHINE;
        if (p == PRIV_USER) begin
            q = PRIV_USER;
        end
        return q;
    endfunction

    // Entry status: previous enable and privilege take the current ones
    function automatic trap_state_t stack_status(input trap_state_t s);
        trap_state_t n;
        n = s;
        n.mpie = s.mie;
        n.mpp = s.priv;
        // Enable is kept, not cleared: nested machine interrupts stay possible
        n.mie = s.mie;
        n.priv = PRIV_MACHINE;
        return n;
    endfunction

    // Return status: enable and privilege come back, previous enable set, previous privilege user
    function automatic trap_state_t unstack_status(input trap_state_t s);
        trap_state_t n;
        n = s;
        n.mie = s.mpie;
        n.priv = legal_priv(s.mpp);
        n.mpie = 1'b1;
        n.mpp = PRIV_USER;
        return n;
    endfunction

    // One-cycle redirect that also flushes younger instructions
    function automatic redirect_t redirect_pulse(input logic [31:0] target);
        redirect_t p;
        p.valid = 1'b1;
        p.flush = 1'b1;
        p.target = target;
        return p;
    endfunction

    // Trap entry: every field and the redirect change in one cycle, so no
    // younger instruction can see a half-updated state
    function automatic trap_state_t enter_trap(input trap_state_t s, input trap_req_t r);
        trap_state_t n;
        n = stack_status(s);
        n.cause = cause_word(r);
        // Pipeline supplies the faulting PC for exceptions, next PC for interrupts
        n.epc = r.pc;
        n.tval = fault_value(r);
        n.redir = redirect_pulse(handler_addr(s.tvec, r.code));
        return n;
    endfunction

    // Trap return: fetch resumes at the saved return PC, which software
    // may have moved past the trapping instruction
    function automatic trap_state_t leave_trap(input trap_state_t s);
        trap_state_t n;
        n = unstack_status(s);
        n.redir = redirect_pulse(s.epc);
        return n;
    endfunction

    // Read data for the selected register; unmapped addresses read zero
    function automatic logic [31:0] csr_read(input trap_state_t s, input csr_sel_t sel);
        logic [31:0] d;
        d = RESET_WORD;
        // Selects are one-hot, so at most one branch fires
        if (sel.status) begin
            d = status_word(s);
        end
        if (sel.tvec) begin
            d = s.tvec;
        end
        if (sel.epc) begin
            d = s.epc;
        end
        if (sel.cause) begin
            d = s.cause;
        end
        if (sel.tval) begin
            d = s.tval;
        end
        return d;
    endfunction

    // Next state: trap entry wins over mret, which wins over a CSR write.
    // A lower-priority request in the same cycle is dropped, not queued:
    // the pipeline flushes it anyway when the redirect lands.
    always_comb begin
        s_d = s_q;
        s_d.redir = '0;
        if (trap_req.valid) begin
            s_d = enter_trap(s_q, trap_req);
        end else if (mret_req) begin
            s_d = leave_trap(s_q);
        end else if (csr_req.wr) begin
            unique case (csr_req.addr)
                CSR_STATUS: begin
                    s_d.mie = csr_req.wdata[STATUS_MIE_BIT];
                    s_d.mpie = csr_req.wdata[STATUS_MPIE_BIT];
                    s_d.mpp = (csr_req.wdata[STATUS_MPP_MSB:STATUS_MPP_LSB] == PRIV_USER) ? PRIV_USER
                                                                                        : PRIV_MACHINE;
                end
                CSR_TVEC: begin
                    // Handler base and mode
                    s_d.tvec = csr_req.wdata;
                end
                CSR_EPC: begin
                    // Bit 0 forced clear so a return never fetches from an odd address
                    s_d.epc = {csr_req.wdata[31:1], 1'b0};
                end
                CSR_CAUSE: begin
                    // Writable so software can fake or clear a cause
                    s_d.cause = csr_req.wdata;
                end
                CSR_TVAL: begin
                    s_d.tval = csr_req.wdata;
                end
                default: begin
                    // Unmapped write: nothing changes
                    s_d.tvec = s_q.tvec;
                end
            endcase
        end
        // Registered read port: a read in the cycle of a write returns the old value
        s_d.rdata = RESET_WORD;
        if (csr_rd) begin
            s_d.rdata = csr_read(s_q, csr_select(csr_req.addr));
        end
    end

    // State register; power-up lands in machine mode with every word cleared
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q.cause <= RESET_WORD;
            s_q.tvec <= RESET_WORD;
            s_q.epc <= RESET_WORD;
            s_q.tval <= RESET_WORD;
            s_q.mie <= 1'b0;
            s_q.mpie <= 1'b0;
            // Previous privilege reads machine so an early mret stays in machine
            s_q.mpp <= PRIV_MACHINE;
            s_q.priv <= PRIV_MACHINE;
            s_q.redir <= '0;
            s_q.rdata <= RESET_WORD;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register; nothing combinational reaches a pin
    // Read data, zero unless a read was strobed the cycle before
    assign csr_rdata = s_q.rdata;
    // Redirect pulse with flush, one cycle wide
    assign redirect = s_q.redir;
    // Current privilege level
    assign priv_mode = s_q.priv;
    // Machine interrupt enable
    assign irq_enable = s_q.mie;

endmodule

// ### design/trap_pkg.sv
// Package for the trap entry and exit unit: constants, codes, carriers.
package trap_pkg;
    // Privilege levels
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;
    // Cause field layout
    localparam int CAUSE_INT_BIT = 31;
    localparam int CAUSE_CODE_MSB = 30;
    // Interrupt numbers
    localparam logic [30:0] IRQ_NMI = 31'h2;
    localparam logic [30:0] IRQ_SYSTEM_TICK_TIMER = 31'hC;
    localparam logic [30:0] IRQ_SOFTWARE = 31'hE;
    localparam logic [30:0] IRQ_EXT_FIRST = 31'h10;
    localparam logic [30:0] IRQ_EXT_LAST = 31'hFF;
    // Exception codes
    localparam logic [30:0] EXC_INSN_MISALIGN = 31'h0;
    localparam logic [30:0] EXC_FETCH_ACCESS = 31'h1;
    localparam logic [30:0] EXC_ILLEGAL_INSN = 31'h2;
    localparam logic [30:0] EXC_BREAKPOINT = 31'h3;
    localparam logic [30:0] EXC_LOAD_MISALIGN = 31'h4;
    localparam logic [30:0] EXC_LOAD_ACCESS = 31'h5;
    localparam logic [30:0] EXC_STORE_MISALIGN = 31'h6;
    localparam logic [30:0] EXC_STORE_ACCESS = 31'h7;
    localparam logic [30:0] EXC_ECALL_USER = 31'h8;
    localparam logic [30:0] EXC_ECALL_MACHINE = 31'hB;
    // Vector base layout and modes
    localparam int TVEC_BASE_LSB = 2;
    localparam logic [1:0] TVEC_MODE_DIRECT = 2'h0;
    localparam logic [1:0] TVEC_MODE_VECTORED = 2'h1;
    localparam int TVEC_SLOT_SHIFT = 2;
    // Status word field positions
    localparam int STATUS_MIE_BIT = 3;
    localparam int STATUS_MPIE_BIT = 7;
    localparam int STATUS_MPP_LSB = 11;
    localparam int STATUS_MPP_MSB = 12;
    // CSR addresses for software access
    localparam logic [11:0] CSR_STATUS = 12'h300;
    localparam logic [11:0] CSR_TVEC = 12'h305;
    localparam logic [11:0] CSR_EPC = 12'h341;
    localparam logic [11:0] CSR_CAUSE = 12'h342;
    localparam logic [11:0] CSR_TVAL = 12'h343;
    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] RESET_STATUS = 32'h0000_1800;

    // Trap report from the pipeline
    typedef struct packed {
        logic valid;
        logic is_irq;
        logic [30:0] code;
        logic [31:0] pc;
        logic [31:0] value;
    } trap_req_t;

    // CSR access from the pipeline
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } csr_req_t;

    // Fetch redirect to the pipeline
    typedef struct packed {
        logic valid;
        logic flush;
        logic [31:0] target;
    } redirect_t;

    // Trap unit state
    typedef struct packed {
        logic [31:0] cause;
        logic [31:0] tvec;
        logic [31:0] epc;
        logic [31:0] tval;
        logic mie;
        logic mpie;
        logic [1:0] mpp;
        logic [1:0] priv;
        redirect_t redir;
        logic [31:0] rdata;
    } trap_state_t;
endpackage

// ### tb/core_pipe_model.sv
// Pipeline model issuing one request per cycle from falling edges
module core_pipe_model
    import trap_pkg::*;
(
    input wire logic ref_clk,
    output trap_req_t trap_req,
    output logic mret_req,
    output logic csr_rd,
    output csr_req_t csr_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Request holds one full cycle; the caller samples answers when it returns
    task automatic step(input trap_req_t t, input logic m, input logic r, input csr_req_t c);
        trap_req <= t;
        mret_req <= m;
        csr_rd <= r;
        csr_req <= c;
        @(negedge ref_clk);
    endtask
endmodule

// ### tb/trap_entry_exit_unit_test.sv
// Self-checking bench for the trap entry and exit unit
module trap_entry_exit_unit_test import trap_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic irq; logic [30:0] code; logic keeps;} row_t;
    localparam logic [31:0] FAULT = 32'hBAD0_0010;
    // Every named cause code, externals only at the two ends of their range, with whether the fault value is kept
    row_t rows [15] = '{'{1'h1, IRQ_NMI, 1'h0}, '{1'h1, IRQ_SYSTEM_TICK_TIMER, 1'h0}, '{1'h1, IRQ_SOFTWARE, 1'h0},
        '{1'h1, IRQ_EXT_FIRST, 1'h0}, '{1'h1, IRQ_EXT_LAST, 1'h0}, '{1'h0, EXC_INSN_MISALIGN, 1'h1},
        '{1'h0, EXC_FETCH_ACCESS, 1'h1}, '{1'h0, EXC_ILLEGAL_INSN, 1'h1}, '{1'h0, EXC_BREAKPOINT, 1'h1},
        '{1'h0, EXC_LOAD_MISALIGN, 1'h1}, '{1'h0, EXC_LOAD_ACCESS, 1'h1}, '{1'h0, EXC_STORE_MISALIGN, 1'h1},
        '{1'h0, EXC_STORE_ACCESS, 1'h1}, '{1'h0, EXC_ECALL_USER, 1'h0}, '{1'h0, EXC_ECALL_MACHINE, 1'h0}};
    logic ref_clk, reset_n, mret_req, csr_rd, irq_enable;
    logic [1:0] priv_mode;
    logic [31:0] csr_rdata;
    trap_req_t trap_req;
    csr_req_t csr_req;
    redirect_t redirect;
    int mismatches, total_checks;
    trap_entry_exit_unit trap_entry_exit_unit_inst (.ref_clk(ref_clk), .reset_n(reset_n), .trap_req(trap_req),
        .mret_req(mret_req), .csr_rd(csr_rd), .csr_req(csr_req), .csr_rdata(csr_rdata), .redirect(redirect),
        .priv_mode(priv_mode), .irq_enable(irq_enable));
    core_pipe_model core_pipe_model_inst (.ref_clk(ref_clk), .trap_req(trap_req), .mret_req(mret_req),
        .csr_rd(csr_rd), .csr_req(csr_req));
    // Word compare; narrow results are zero-extended by the caller
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One-cycle requests; calls must follow each other with no time between
    task automatic trap(input logic irq, input logic [30:0] code, input logic [31:0] pc);
        core_pipe_model_inst.step('{1'h1, irq, code, pc, FAULT}, 1'h0, 1'h0, '0);
    endtask
    task automatic ret(input logic [31:0] target);
        core_pipe_model_inst.step('0, 1'h1, 1'h0, '0);
        check(redirect.target, target);
        check({30'h0, redirect.valid, redirect.flush}, 32'h3);
    endtask
    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        core_pipe_model_inst.step('0, 1'h0, 1'h0, '{1'h1, addr, data});
    endtask
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        core_pipe_model_inst.step('0, 1'h0, 1'h1, '{1'h0, addr, 32'h0});
        check(csr_rdata, exp);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Clock, and a watchdog far beyond the run's 88 cycles
    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end
    initial begin
        reset_n = 1'h0;
        core_pipe_model_inst.step('0, 1'h0, 1'h0, '0);
        repeat (9) @(negedge ref_clk);
        reset_n = 1'h1;
        check({30'h0, priv_mode}, 32'h3);
        rd(CSR_STATUS, RESET_STATUS);
        wr(CSR_TVEC, 32'h2000_0001);
        for (int i = 0; i < 15; i++) begin
            trap(rows[i].irq, rows[i].code, 32'h100 + 32'(i * 4));
            check(redirect.target, 32'h2000_0000 + {rows[i].code[29:0], 2'h0});
            rd(CSR_CAUSE, {rows[i].irq, rows[i].code});
            rd(CSR_EPC, 32'h100 + 32'(i * 4));
            rd(CSR_TVAL, rows[i].keeps ? FAULT : 32'h0);
        end
        ret(32'h138);
        check({30'h0, priv_mode}, 32'h3);
        // Direct mode and a round trip through user mode
        wr(CSR_TVEC, 32'h3000_0000);
        wr(CSR_STATUS, 32'h0000_0088);
        ret(32'h138);
        check({29'h0, priv_mode, irq_enable}, 32'h1);
        trap(1'h0, EXC_ECALL_USER, 32'h400);
        check(redirect.target, 32'h3000_0000);
        check({29'h0, priv_mode, irq_enable}, 32'h7);
        rd(CSR_STATUS, 32'h0000_0088);
        wr(CSR_EPC, 32'h404);
        wr(CSR_STATUS, 32'h0000_0080);
        ret(32'h404);
        check({29'h0, priv_mode, irq_enable}, 32'h1);
        // Return right behind entry, then an unmapped read
        trap(1'h1, IRQ_SOFTWARE, 32'h500);
        ret(32'h500);
        check({29'h0, priv_mode, irq_enable}, 32'h1);
        rd(12'h7C0, 32'h0);
        // Reset in mid-run from user mode: machine mode and cleared words return
        reset_n = 1'h0;
        core_pipe_model_inst.step('0, 1'h0, 1'h0, '0);
        reset_n = 1'h1;
        check({29'h0, priv_mode, irq_enable}, 32'h6);
        rd(CSR_EPC, 32'h0);
        rd(CSR_STATUS, RESET_STATUS);
        core_pipe_model_inst.step('0, 1'h0, 1'h0, '0);
        close_out();
    end
endmodule
bind trap_entry_exit_unit trap_unit_checker trap_unit_checker_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .trap_req(trap_req), .mret_req(mret_req), .csr_rd(csr_rd), .csr_req(csr_req), .csr_rdata(csr_rdata),
    .redirect(redirect), .priv_mode(priv_mode), .irq_enable(irq_enable));

// ### tb/trap_unit_assertions.sv
// Port-level checker for the trap entry and exit unit
module trap_unit_checker
    import trap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input trap_req_t trap_req,
    input wire logic mret_req,
    input wire logic csr_rd,
    input csr_req_t csr_req,
    input logic [31:0] csr_rdata,
    input redirect_t redirect,
    input logic [1:0] priv_mode,
    input logic irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Every entry, and every return not displaced by a trap, lands exactly one cycle after its request
    trap_redirect_a: assert property (trap_req.valid |=> redirect.valid && redirect.flush)
        else $error("trap not redirected");
    trap_machine_a: assert property (trap_req.valid |=> priv_mode == PRIV_MACHINE)
        else $error("trap left privilege");
    trap_keeps_mie_a: assert property (trap_req.valid |=> $stable(irq_enable))
        else $error("trap changed enable");
    mret_redirect_a: assert property (mret_req && !trap_req.valid |=> redirect.valid && redirect.flush)
        else $error("return not redirected");
    no_spurious_a: assert property (!trap_req.valid && !mret_req |=> !redirect.valid)
        else $error("redirect without cause");
    // A trap followed at once by a return must give back the state from before the trap
    round_mie_a: assert property (trap_req.valid ##1 mret_req |=> irq_enable == $past(irq_enable, 2))
        else $error("enable not restored");
    round_priv_a: assert property (trap_req.valid ##1 (mret_req && !trap_req.valid) |=> priv_mode == $past(priv_mode, 2))
        else $error("privilege not restored");
    reset_machine_a: assert property ($rose(reset_n) |-> priv_mode == PRIV_MACHINE)
        else $error("not machine after reset");
endmodule
